// ==== core/pg_pkg.sv ====
// constants, types and helpers shared by the link-good pin control block
//
// Function
// - each pin has one direction bit: zero makes it an input, one an output.
// - an input pin with selector 00b is captured into its bit of the input data register at 61Ch.
// - an input pin with selector 01b is routed to the general interrupt path.
// - an output pin with selector 00b is driven from its bit of the output data register at 624h.
// - an output pin with selector 01b is driven with its port's link-good indication.
// - after reset a selector is 01b when the strap is 1011b or 1101b and the port is enabled, else 00b.
// - after reset a direction bit is one under that same condition, else zero.
// - the register packs a two-bit selector then a direction bit per pin, for all ten pins of the bank in order.
// - a pin's data-register bit index equals its position in the bank, port 0 at bit 0.
// - the registers answer in base mode, but in virtual switch mode only to the management port.
// - the space spans 600h to 68Ch, with 670h-67Ch reserved in base mode and 680h-68Ch reserved.
// - the tenth pin uses selector bits 28:27, direction bit 29 and data bit 9; bits 31:30 are reserved.
package pg_pkg;

    localparam int          PIN_COUNT       = 10;
    localparam int          FIELD_STRIDE    = 3;
    localparam int          DIR_BIT_POS     = 2;
    localparam int          SEL_WIDTH       = 2;

    localparam logic [11:0] SPACE_LO        = 12'h600;
    localparam logic [11:0] SPACE_HI        = 12'h68c;
    localparam logic [11:0] DIR_CTRL_OFFSET = 12'h600;
    localparam logic [11:0] IN_DATA_OFFSET  = 12'h61c;
    localparam logic [11:0] OUT_DATA_OFFSET = 12'h624;
    localparam logic [11:0] SHP_ASSIGN_LO   = 12'h670;
    localparam logic [11:0] SHP_ASSIGN_HI   = 12'h67c;
    localparam logic [11:0] RSVD_TAIL_LO    = 12'h680;

    localparam logic [31:0] DIR_CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] DIR_CTRL_MASK   = 32'h3fff_ffff;
    localparam logic [9:0]  DATA_RESET      = 10'h000;

    localparam logic [1:0]  SEL_DATA        = 2'h0;
    localparam logic [1:0]  SEL_ALT         = 2'h1;
    localparam logic [3:0]  STRAP_PG_A      = 4'hb;
    localparam logic [3:0]  STRAP_PG_B      = 4'hd;

    // cycles counted in ST_HOLD after reset release: the two sync stages; the strap load comes two cycles later
    localparam logic [1:0]  STRAP_SETTLE    = 2'h2;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_s;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } boot_state_e;

    function automatic logic [1:0] field_sel(input logic [31:0] r, input int i);
        return r[i*FIELD_STRIDE +: SEL_WIDTH];
    endfunction

    function automatic logic field_dir(input logic [31:0] r, input int i);
        return r[i*FIELD_STRIDE + DIR_BIT_POS];
    endfunction

    function automatic logic [31:0] apply_be(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        return r;
    endfunction

    function automatic logic [31:0] strap_default(input logic [3:0] strap,
                                                   input logic [9:0] port_en);
        logic [31:0] r;
        r = DIR_CTRL_RESET;
        for (int i = 0; i < PIN_COUNT; i++)
            if ((strap == STRAP_PG_A || strap == STRAP_PG_B) && port_en[i])
            begin
                r[i*FIELD_STRIDE +: SEL_WIDTH]   = SEL_ALT;
                r[i*FIELD_STRIDE + DIR_BIT_POS]  = 1'b1;
            end
        return r;
    endfunction

endpackage

// ==== core/pin_sync.sv ====
// two-stage synchroniser for pin-level inputs
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // pin_sync

// ==== core/pin_cell.sv ====
// per-pin source and destination steering
module pin_cell
    import pg_pkg::*;
(
    input  wire logic       dir,
    input  wire logic [1:0] sel,
    input  wire logic       out_data,
    input  wire logic       link_up,
    input  wire logic       pin_level,
    output logic            pin_out,
    output logic            pin_oe,
    output logic            capture,
    output logic            irq_level
);
    always_comb
    begin
        pin_oe    = dir;
        capture   = !dir && sel == SEL_DATA;
        irq_level = !dir && sel == SEL_ALT && pin_level;
        case (sel)
            SEL_DATA: pin_out = out_data;
            // indicator is active low on the pin
            SEL_ALT:  pin_out = !link_up;
            // reserved codes park the pin at its inactive level
            default:  pin_out = 1'b1;
        endcase
    end
endmodule // pin_cell

// ==== core/port_good_pin_ctrl.sv ====
// direction, source and data registers for the link-good pin bank
module port_good_pin_ctrl
    import pg_pkg::*;
(
    input  wire logic                 CLOCK,
    input  wire logic                 RST,
    input  wire cfg_req_s             CFG_REQ,
    input  wire logic                 VS_MODE,
    input  wire logic                 FROM_MGMT_PORT,
    output logic [31:0]               CFG_RDATA,
    output logic                      CFG_RVALID,
    input  wire logic [3:0]           TEST_MODE_STRAP,
    input  wire logic [PIN_COUNT-1:0] PORT_ENABLE,
    input  wire logic [PIN_COUNT-1:0] PORT_LINK_UP,
    input  wire logic [PIN_COUNT-1:0] LINK_GOOD_PIN_IN,
    output logic      [PIN_COUNT-1:0] LINK_GOOD_PIN_OUT,
    output logic      [PIN_COUNT-1:0] LINK_GOOD_PIN_OE,
    output logic      [PIN_COUNT-1:0] GENERAL_IRQ_LEVEL
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    boot_state_e              state;
    boot_state_e              next_state;
    logic [1:0]               settle;
    logic [31:0]              dir_ctrl;
    logic [PIN_COUNT-1:0]     in_data;
    logic [PIN_COUNT-1:0]     out_data;
    logic [3:0]               strap_sync;
    logic [PIN_COUNT-1:0]     pin_level;
    logic [PIN_COUNT-1:0]     dir_vec;
    logic [PIN_COUNT-1:0]     sel_data_vec;
    logic [PIN_COUNT-1:0]     sel_alt_vec;
    logic [PIN_COUNT-1:0]     capture;
    logic                     access_ok;
    logic                     in_space;
    logic                     wr_ok;
    logic                     rd_ok;
    logic [31:0]              next_rdata;
    logic [31:0]              out_word;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    pin_sync #(.WIDTH(4)) u_strap_sync (
        .clk (CLOCK),
        .rst (RST),
        .d   (TEST_MODE_STRAP),
        .q   (strap_sync)
    );

    pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
        .clk (CLOCK),
        .rst (RST),
        .d   (LINK_GOOD_PIN_IN),
        .q   (pin_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // per-pin steering

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++)
        begin : g_pin
            assign dir_vec[g]      = field_dir(dir_ctrl, g);
            assign sel_data_vec[g] = field_sel(dir_ctrl, g) == SEL_DATA;
            assign sel_alt_vec[g]  = field_sel(dir_ctrl, g) == SEL_ALT;

            pin_cell u_cell (
                .dir       (field_dir(dir_ctrl, g)),
                .sel       (field_sel(dir_ctrl, g)),
                .out_data  (out_data[g]),
                .link_up   (PORT_LINK_UP[g]),
                .pin_level (pin_level[g]),
                .pin_out   (LINK_GOOD_PIN_OUT[g]),
                .pin_oe    (LINK_GOOD_PIN_OE[g]),
                .capture   (capture[g]),
                .irq_level (GENERAL_IRQ_LEVEL[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // strap capture after reset release; straps are not constants under reset

    always_comb
    begin
        next_state = state;
        case (state)
            ST_HOLD: if (settle == STRAP_SETTLE) next_state = ST_LOAD;
            ST_LOAD: next_state = ST_RUN;
            ST_RUN:  next_state = ST_RUN;
            default: next_state = ST_HOLD;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            state <= ST_HOLD;
        else
            state <= next_state;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            settle <= 2'h0;
        else if (state == ST_HOLD && settle != STRAP_SETTLE)
            settle <= settle + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // access decode

    // virtual switch mode hides the bank from all but the management port
    assign access_ok = !VS_MODE || FROM_MGMT_PORT;
    assign in_space  = CFG_REQ.addr >= SPACE_LO && CFG_REQ.addr <= SPACE_HI;
    // writes before the strap load would be overwritten, so they are refused
    assign wr_ok     = CFG_REQ.wr && access_ok && state == ST_RUN;
    assign rd_ok     = CFG_REQ.rd && access_ok && in_space;
    // output data merged by byte lane, only the low pin bits are kept
    assign out_word  = apply_be({22'h0, out_data}, CFG_REQ.wdata, CFG_REQ.be);

    always_comb
    begin
        next_rdata = 32'h0;
        case (CFG_REQ.addr)
            DIR_CTRL_OFFSET: next_rdata = dir_ctrl;
            IN_DATA_OFFSET:  next_rdata = {22'h0, in_data};
            OUT_DATA_OFFSET: next_rdata = {22'h0, out_data};
            default:         next_rdata = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            dir_ctrl <= DIR_CTRL_RESET;
        else if (state == ST_LOAD)
            dir_ctrl <= strap_default(strap_sync, PORT_ENABLE);
        else if (wr_ok && CFG_REQ.addr == DIR_CTRL_OFFSET)
            dir_ctrl <= apply_be(dir_ctrl, CFG_REQ.wdata, CFG_REQ.be)
                        & DIR_CTRL_MASK;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            out_data <= DATA_RESET;
        else if (wr_ok && CFG_REQ.addr == OUT_DATA_OFFSET)
            out_data <= out_word[PIN_COUNT-1:0];
    end

    // pins not captured hold their last sample
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            in_data <= DATA_RESET;
        else
            in_data <= (capture & pin_level) | (~capture & in_data);
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            CFG_RDATA  <= 32'h0;
            CFG_RVALID <= 1'b0;
        end
        else
        begin
            CFG_RVALID <= CFG_REQ.rd;
            if (CFG_REQ.rd)
                CFG_RDATA <= rd_ok ? next_rdata : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_input_no_drive: assert property (@(posedge CLOCK) disable iff (RST)
        (LINK_GOOD_PIN_OE & ~dir_vec) == '0)
        else $error("driver enabled on an input pin");

    a_data_drive_out: assert property (@(posedge CLOCK) disable iff (RST)
        ((dir_vec & sel_data_vec) & (LINK_GOOD_PIN_OUT ^ out_data)) == '0)
        else $error("output pin does not follow output data");

    a_link_good_drive: assert property (@(posedge CLOCK) disable iff (RST)
        ((dir_vec & sel_alt_vec) & (LINK_GOOD_PIN_OUT ^ ~PORT_LINK_UP)) == '0)
        else $error("link-good pin not following port state");

    a_input_capture: assert property (@(posedge CLOCK) disable iff (RST)
        (~dir_vec & sel_data_vec) != '0
        |=> ((($past(~dir_vec & sel_data_vec)) & (in_data ^ $past(pin_level))) == '0))
        else $error("input data register missed a pin sample");

    a_irq_route: assert property (@(posedge CLOCK) disable iff (RST)
        GENERAL_IRQ_LEVEL == (~dir_vec & sel_alt_vec & pin_level))
        else $error("interrupt routing wrong");

    a_strap_default: assert property (@(posedge CLOCK) disable iff (RST)
        state == ST_LOAD |=> dir_ctrl == strap_default($past(strap_sync),
                                                        $past(PORT_ENABLE)))
        else $error("strap default not loaded");

    a_boot_timing: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(settle == STRAP_SETTLE) |=> state == ST_LOAD ##1 state == ST_RUN)
        else $error("strap load out of sequence");

    a_vs_block_write: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG_REQ.wr && VS_MODE && !FROM_MGMT_PORT && state == ST_RUN)
        |=> $stable(dir_ctrl) && $stable(out_data))
        else $error("write from a non-management port took effect");

    a_reserved_read: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG_REQ.rd && CFG_REQ.addr >= SHP_ASSIGN_LO) |=> CFG_RDATA == 32'h0)
        else $error("reserved offset read non-zero");

    a_reserved_bits: assert property (@(posedge CLOCK) disable iff (RST)
        dir_ctrl[31:30] == 2'b00)
        else $error("reserved direction bits set");

    a_dir_readback: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG_REQ.rd && access_ok && CFG_REQ.addr == DIR_CTRL_OFFSET)
        |=> CFG_RVALID && CFG_RDATA == $past(dir_ctrl))
        else $error("direction register readback wrong");

    a_oe_follow_dir: assert property (@(posedge CLOCK) disable iff (RST)
        LINK_GOOD_PIN_OE == dir_vec)
        else $error("driver enable differs from direction bit");

    a_out_park: assert property (@(posedge CLOCK) disable iff (RST)
        ((dir_vec & ~sel_data_vec & ~sel_alt_vec) & ~LINK_GOOD_PIN_OUT) == '0)
        else $error("reserved source code not parked high");

    a_in_data_hold: assert property (@(posedge CLOCK) disable iff (RST)
        1'b1 |=> ((~$past(capture)) & (in_data ^ $past(in_data))) == '0)
        else $error("input data changed on a pin not captured");

    a_early_wr_drop: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG_REQ.wr && state == ST_HOLD) |=> $stable(dir_ctrl) && $stable(out_data))
        else $error("write before strap load took effect");

    a_boot_no_drive: assert property (@(posedge CLOCK) disable iff (RST)
        state != ST_RUN |-> LINK_GOOD_PIN_OE == '0)
        else $error("pin driven before strap load");

    a_rvalid_pulse: assert property (@(posedge CLOCK) disable iff (RST)
        CFG_REQ.rd |=> CFG_RVALID)
        else $error("read answer missing");

    a_rvalid_idle: assert property (@(posedge CLOCK) disable iff (RST)
        !CFG_REQ.rd |=> !CFG_RVALID)
        else $error("read answer without request");

    a_out_readback: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG_REQ.rd && access_ok && CFG_REQ.addr == OUT_DATA_OFFSET)
        |=> CFG_RDATA == {22'h0, $past(out_data)})
        else $error("output data readback wrong");

    a_in_readback: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG_REQ.rd && access_ok && CFG_REQ.addr == IN_DATA_OFFSET)
        |=> CFG_RDATA == {22'h0, $past(in_data)})
        else $error("input data readback wrong");

    a_denied_read: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG_REQ.rd && VS_MODE && !FROM_MGMT_PORT) |=> CFG_RDATA == 32'h0)
        else $error("denied read returned data");

    ////////////////////////////////////////////////////////////////////////////////
    // scenario covers

    c_mgmt_write: cover property (@(posedge CLOCK) disable iff (RST)
        CFG_REQ.wr && VS_MODE && FROM_MGMT_PORT && state == ST_RUN);

    c_strap_alt: cover property (@(posedge CLOCK) disable iff (RST)
        state == ST_LOAD ##1 (dir_vec & sel_alt_vec) != '0);

    c_link_good_out: cover property (@(posedge CLOCK) disable iff (RST)
        (dir_vec & sel_alt_vec & ~PORT_LINK_UP) != '0);

    c_input_read: cover property (@(posedge CLOCK) disable iff (RST)
        CFG_REQ.rd && CFG_REQ.addr == IN_DATA_OFFSET && in_data != '0);

    c_refused_write: cover property (@(posedge CLOCK) disable iff (RST)
        CFG_REQ.wr && !access_ok && state == ST_RUN);

endmodule // port_good_pin_ctrl

// ==== dv/pin_board_model.sv ====
// board-side model of the link-good pin bank
module pin_board_model
    import pg_pkg::*;
(
    input  wire logic [PIN_COUNT-1:0] pin_out,
    input  wire logic [PIN_COUNT-1:0] pin_oe,
    input  wire logic [PIN_COUNT-1:0] ext_drive,
    output logic      [PIN_COUNT-1:0] pin_level
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////////
    // board drives a pin only where the block lets go of it
    always_comb
        for (int i = 0; i < PIN_COUNT; i++)
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_drive[i];
endmodule // pin_board_model

// ==== dv/port_good_pin_direction_control_tb_top.sv ====
// self-checking bench for the link-good pin control block
module port_good_pin_direction_control_tb_top
    import pg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock     = 1'b0;
    logic        rst       = 1'b1;
    cfg_req_s    req       = '0;
    logic        vs_mode   = 1'b0;
    logic        from_mgmt = 1'b0;
    logic [3:0]  strap     = 4'h0;
    logic [9:0]  port_en   = 10'h000;
    logic [9:0]  link_up   = 10'h000;
    logic [9:0]  ext_drive = 10'h000;
    logic [31:0] rdata;
    logic        rvalid;
    logic [9:0]  pin_in;
    logic [9:0]  pin_out;
    logic [9:0]  pin_oe;
    logic [9:0]  irq;
    logic [31:0] v;
    int          error_cnt = 0;
    int          n_tests   = 0;

    port_good_pin_ctrl port_good_pin_ctrl_inst (
        .CLOCK(clock), .RST(rst), .CFG_REQ(req), .VS_MODE(vs_mode),
        .FROM_MGMT_PORT(from_mgmt), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
        .TEST_MODE_STRAP(strap), .PORT_ENABLE(port_en), .PORT_LINK_UP(link_up),
        .LINK_GOOD_PIN_IN(pin_in), .LINK_GOOD_PIN_OUT(pin_out),
        .LINK_GOOD_PIN_OE(pin_oe), .GENERAL_IRQ_LEVEL(irq)
    );

    pin_board_model pin_board_model_inst (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive), .pin_level(pin_in)
    );

    initial
    begin
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // dir and selector-01 masks into the packed three-bit fields
    function automatic logic [31:0] pack(input logic [9:0] d, input logic [9:0] s);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 10; i++)
            r[i*3 +: 3] = {d[i], 1'b0, s[i]};
        return r;
    endfunction

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic cfg_wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clock);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    task automatic cfg_rd(input logic [11:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0};
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        while (rvalid !== 1'b1 && n < 4)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 4)
        begin
            error_cnt++;
            $display("[FAIL] read answer expected 1 seen 0");
            give_verdict();
        end
        d = rdata;
    endtask

    task automatic do_reset(input logic [3:0] s, input logic [9:0] pe);
        @(posedge clock);
        strap <= s;
        port_en <= pe;
        rst <= 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic strap_defaults();
        logic [3:0] s [5] = '{4'hb, 4'hd, 4'hc, 4'h0, 4'hb};
        logic [9:0] p [5] = '{10'h2a5, 10'h35a, 10'h3ff, 10'h3ff, 10'h3ff};
        logic [9:0] hit;
        for (int k = 0; k < 5; k++)
        begin
            do_reset(s[k], p[k]);
            hit = (s[k] == 4'hb || s[k] == 4'hd) ? p[k] : 10'h000;
            cfg_rd(12'h600, v);
            chk("strap default", pack(hit, hit), v);
            chk("default oe", {22'h0, hit}, {22'h0, pin_oe});
        end
    endtask

    task automatic output_data();
        do_reset(4'h0, 10'h3ff);
        // only codes 00b and 01b are ever programmed
        cfg_wr(12'h600, 4'hf, pack(10'h3ff, 10'h000));
        cfg_wr(12'h624, 4'hf, 32'h155);
        settle(1);
        chk("out data", 32'h155, {22'h0, pin_out});
        chk("out oe", 32'h3ff, {22'h0, pin_oe});
        cfg_wr(12'h624, 4'hf, 32'h2aa);
        cfg_wr(12'h600, 4'hf, pack(10'h0f0, 10'h000));
        settle(1);
        chk("mixed oe", 32'h0f0, {22'h0, pin_oe});
        chk("mixed out", 32'h0a0, {22'h0, pin_out & pin_oe});
        cfg_rd(12'h624, v);
        chk("out data read", 32'h2aa, v);
    endtask

    task automatic link_good_out();
        cfg_wr(12'h600, 4'hf, pack(10'h3ff, 10'h3ff));
        @(posedge clock);
        link_up <= 10'h30c;
        settle(1);
        chk("link good out", 32'h0f3, {22'h0, pin_out});
        link_up <= 10'h0c3;
        settle(1);
        chk("link good out", 32'h33c, {22'h0, pin_out});
    endtask

    task automatic input_paths();
        cfg_wr(12'h600, 4'hf, pack(10'h000, 10'h000));
        ext_drive <= 10'h1b6;
        settle(5);
        chk("input oe", 32'h0, {22'h0, pin_oe});
        chk("irq idle", 32'h0, {22'h0, irq});
        cfg_rd(12'h61c, v);
        chk("in data", 32'h1b6, v);
        cfg_wr(12'h600, 4'hf, pack(10'h000, 10'h3ff));
        ext_drive <= 10'h249;
        settle(5);
        chk("irq route", 32'h249, {22'h0, irq});
        chk("irq oe", 32'h0, {22'h0, pin_oe});
        cfg_rd(12'h61c, v);
        chk("in data held", 32'h1b6, v);
    endtask

    task automatic access_rules();
        logic [11:0] rsv [5] = '{12'h604, 12'h670, 12'h67c, 12'h680, 12'h68c};
        cfg_wr(12'h600, 4'hf, 32'hc000_0000 | pack(10'h155, 10'h000));
        cfg_rd(12'h600, v);
        chk("top bits", pack(10'h155, 10'h000), v);
        // lane 0 only: upper lanes keep the old fields
        cfg_wr(12'h600, 4'h1, pack(10'h3ff, 10'h000));
        cfg_rd(12'h600, v);
        // upper three lanes of the earlier word, lane 0 from the new one
        chk("byte lane", 32'h0410_4124, v);
        foreach (rsv[k])
        begin
            cfg_wr(rsv[k], 4'hf, 32'hffff_ffff);
            cfg_rd(rsv[k], v);
            chk("reserved", 32'h0, v);
        end
        cfg_wr(12'h624, 4'hf, 32'h00f);
        @(posedge clock);
        vs_mode <= 1'b1;
        cfg_rd(12'h600, v);
        chk("vs denied read", 32'h0, v);
        cfg_wr(12'h624, 4'hf, 32'h3ff);
        @(posedge clock);
        from_mgmt <= 1'b1;
        cfg_rd(12'h624, v);
        chk("vs denied write", 32'h00f, v);
        cfg_wr(12'h624, 4'hf, 32'h0f0);
        cfg_rd(12'h624, v);
        chk("vs mgmt write", 32'h0f0, v);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        strap_defaults();
        output_data();
        link_good_out();
        input_paths();
        access_rules();
        give_verdict();
    end
endmodule // port_good_pin_direction_control_tb_top
